// [rtl/tfc_pkg.sv]
// constants shared by the translation fault event classifier
package tfc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK   = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0c;
  localparam logic [7:0] REG_LAST   = 8'h10;
  // control register bit positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CHECK_BIT  = 1;
  localparam int CTRL_MERGE_BIT  = 2;
  localparam int CTRL_REV0_BIT   = 3;
  localparam logic [3:0] CTRL_RESET  = 4'h0;
  localparam logic [3:0] MASK_RESET  = 4'h0;
  // status bit per event
  localparam int EVT_FORBID  = 0;
  localparam int EVT_BADSUB  = 1;
  localparam int EVT_FETCH   = 2;
  localparam int EVT_BADDESC = 3;
  localparam int EVT_NUM     = 4;
  // event codes
  localparam logic [7:0] CODE_FORBID  = 8'h07;
  localparam logic [7:0] CODE_BADSUB  = 8'h08;
  localparam logic [7:0] CODE_FETCH   = 8'h09;
  localparam logic [7:0] CODE_BADDESC = 8'h0a;
  // record word 0 layout
  localparam int W0_SUB_LSB   = 12;
  localparam int W0_VALID_BIT = 11;
  // record shape
  localparam int REC_WORDS = 8;
  localparam int MERGE_LSB = 12;
  // entry field encodings
  localparam logic [2:0] CFG_FULL_BYPASS = 3'b100;
  localparam logic [1:0] ATS_DENIED      = 2'b00;
  localparam logic [1:0] DSS_INDEX_ZERO  = 2'b10;
  // recording state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EMIT = 2'b10
  } tfc_state_t;
endpackage

// [rtl/tfc_sticky_bit.sv]
// one sticky event status bit with mask and write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module tfc_sticky_bit
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic setEvt,
  input  wire logic clrBit,
  input  wire logic maskBit,
  output logic      stat,
  output logic      pend
);
  logic stat_q;
  logic stat_d;

  // an event in the clearing cycle survives
  assign stat_d = setEvt | (stat_q & ~clrBit);
  assign stat   = stat_q;
  assign pend   = stat_q & maskBit;

  // status flop
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      stat_q <= 1'b0;
    else
      stat_q <= stat_d;
  end
endmodule // tfc_sticky_bit
`default_nettype wire

// [rtl/tfc_classifier.sv]
// translation fault event classifier with record output and apb registers
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tfc_classifier
  import tfc_pkg::*;
#(
  parameter int SUB_W = 20
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  irq,
  // incoming transaction with its entry fields
  input  wire logic             txnValid,
  output logic                  txnReady,
  input  wire logic             txnTranslated,
  input  wire logic             secureStreamFlag,
  input  wire logic [31:0]      streamIdentifier,
  input  wire logic             substreamValid,
  input  wire logic [SUB_W-1:0] substreamIdentifier,
  input  wire logic [63:0]      inputAddress,
  input  wire logic             entryValid,
  input  wire logic [1:0]       entryAtsPermission,
  input  wire logic [2:0]       entryStageConfiguration,
  input  wire logic [SUB_W-1:0] substreamLimitField,
  // descriptor fetch outcome
  input  wire logic             fetchValid,
  output logic                  fetchReady,
  input  wire logic [31:0]      fetchStream,
  input  wire logic             fetchSubValid,
  input  wire logic [SUB_W-1:0] fetchSubId,
  input  wire logic [SUB_W-1:0] fetchDescIndex,
  input  wire logic [1:0]       defaultSubstreamSelect,
  input  wire logic             fetchAbort,
  input  wire logic             fetchRangeError,
  input  wire logic             fetchFirstInvalid,
  input  wire logic             fetchPointerRange,
  input  wire logic             fetchDescInvalid,
  input  wire logic             fetchDescIllegal,
  input  wire logic [51:0]      fetchPhysicalAddress,
  input  wire logic [31:0]      fetchCause,
  // event record writer
  output logic                  recValid,
  input  wire logic             recReady,
  output logic [31:0]           recData,
  output logic                  recLast
);
  tfc_state_t state_q;
  tfc_state_t state_d;
  logic [3:0]  ctrl_q;
  logic [3:0]  mask_q;
  logic [15:0] recCount_q;
  logic [15:0] mergeCount_q;
  logic [7:0]  lastCode_q;
  logic [2:0]  wordCnt_q;
  logic [31:0] recWords_q [REC_WORDS];
  logic [31:0] recNext [REC_WORDS];
  logic        keyValid_q;
  logic [31:0] keyStream_q;
  logic [51:0] keyPage_q;
  logic [EVT_NUM-1:0] statBits;
  logic [EVT_NUM-1:0] pendBits;
  logic [EVT_NUM-1:0] evtSet;

  // apb decode
  wire apbAcc   = psel & penable;
  wire apbWr    = apbAcc & pwrite;
  wire hitCtrl  = paddr == REG_CTRL;
  wire hitStat  = paddr == REG_STATUS;
  wire hitMask  = paddr == REG_MASK;
  wire hitCount = paddr == REG_COUNT;
  wire hitLast  = paddr == REG_LAST;
  wire hitAny   = hitCtrl | hitStat | hitMask | hitCount | hitLast;

  // control fields
  wire globalEnable = ctrl_q[CTRL_ENABLE_BIT];
  wire atsCheck     = ctrl_q[CTRL_CHECK_BIT];
  wire mergeEnable  = ctrl_q[CTRL_MERGE_BIT];
  wire firstRev     = ctrl_q[CTRL_REV0_BIT];

  // handshakes, fetch outcomes take precedence
  wire idle      = state_q == ST_IDLE;
  assign fetchReady = idle;
  assign txnReady   = idle & ~fetchValid;
  wire txnTake   = txnValid & txnReady;
  wire fetchTake = fetchValid & fetchReady;
  wire recTake   = recValid & recReady;

  // forbidden translated traffic
  wire bypassDenied = atsCheck & entryValid
    & (entryAtsPermission == ATS_DENIED
       | entryStageConfiguration == CFG_FULL_BYPASS);
  wire forbidHit = txnTranslated
    & (bypassDenied | secureStreamFlag | ~globalEnable);

  // merge key drops the page offset bits
  wire mergeHit = forbidHit & mergeEnable & keyValid_q
    & keyStream_q == streamIdentifier
    & keyPage_q == inputAddress[63:MERGE_LSB];

  // bad substream on the transaction path, stage 2 state not looked at
  wire badSubHit = ~forbidHit & substreamValid
    & (~entryStageConfiguration[0]
       | substreamLimitField == '0
       | substreamIdentifier >= substreamLimitField);

  // fetch path classification
  wire abortHit   = fetchAbort | (firstRev & fetchRangeError);
  wire firstHit   = ~abortHit & (fetchFirstInvalid | fetchPointerRange);
  wire descHit    = ~abortHit & ~firstHit
    & (fetchDescInvalid | fetchDescIllegal);
  wire dssZero    = ~fetchSubValid & defaultSubstreamSelect == DSS_INDEX_ZERO;
  wire [SUB_W-1:0] badSubField =
    ~fetchPointerRange ? fetchSubId :
    dssZero            ? '0 :
                         fetchDescIndex;

  // which event is recorded this cycle
  wire txnRec   = txnTake & ((forbidHit & ~mergeHit) | badSubHit);
  wire fetchRec = fetchTake & (abortHit | firstHit | descHit);
  assign evtSet[EVT_FORBID]  = txnTake & forbidHit;
  assign evtSet[EVT_BADSUB]  = (txnTake & badSubHit) | (fetchTake & firstHit);
  assign evtSet[EVT_FETCH]   = fetchTake & abortHit;
  assign evtSet[EVT_BADDESC] = fetchTake & descHit;

  // fetch address with reserved top nibble in the first revision
  wire [51:0] addrOut = {fetchPhysicalAddress[51:48] & {4{~firstRev}},
                         fetchPhysicalAddress[47:0]};

  // record assembly, every undefined word stays zero
  always_comb
  begin
    for (int i = 0; i < REC_WORDS; i++)
      recNext[i] = 32'h0;
    if (fetchTake)
    begin
      recNext[1] = fetchStream;
      if (abortHit)
      begin
        recNext[0] = {fetchSubId, fetchSubValid, 3'h0, CODE_FETCH};
        recNext[2] = fetchCause;
        recNext[6] = {addrOut[31:3], 3'h0};
        recNext[7] = {12'h0, addrOut[51:32]};
      end
      else if (firstHit)
        recNext[0] = {badSubField, 1'b0, 3'h0, CODE_BADSUB};
      else
        recNext[0] = {fetchSubId, fetchSubValid, 3'h0, CODE_BADDESC};
    end
    else
    begin
      recNext[1] = streamIdentifier;
      if (forbidHit)
      begin
        recNext[0] = {24'h0, CODE_FORBID};
        recNext[4] = inputAddress[31:0];
        recNext[5] = inputAddress[63:32];
      end
      else
        recNext[0] = {substreamIdentifier, 1'b0, 3'h0, CODE_BADSUB};
    end
  end

  // next state
  always_comb
  begin
    case (state_q)
      ST_IDLE: state_d = (txnRec | fetchRec) ? ST_EMIT : ST_IDLE;
      ST_EMIT: state_d = (recTake & recLast) ? ST_IDLE : ST_EMIT;
      default: state_d = ST_IDLE;
    endcase
  end

  // record output from the head of the word shifter
  assign recValid = state_q == ST_EMIT;
  assign recData  = recWords_q[0];
  assign recLast  = wordCnt_q == 3'(REC_WORDS - 1);

  // state and word counter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= ST_IDLE;
      wordCnt_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      if (idle)
        wordCnt_q <= 3'h0;
      else if (recTake)
        wordCnt_q <= wordCnt_q + 3'h1;
    end
  end

  // load a fresh record or shift one word out
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < REC_WORDS; i++)
        recWords_q[i] <= 32'h0;
    end
    else if (txnRec | fetchRec)
    begin
      for (int i = 0; i < REC_WORDS; i++)
        recWords_q[i] <= recNext[i];
    end
    else if (recTake)
    begin
      for (int i = 0; i < REC_WORDS - 1; i++)
        recWords_q[i] <= recWords_q[i + 1];
      recWords_q[REC_WORDS - 1] <= 32'h0;
    end
  end

  // merge key of the last forbidden record, lost on any other record
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      keyValid_q  <= 1'b0;
      keyStream_q <= 32'h0;
      keyPage_q   <= 52'h0;
    end
    else if (txnRec & forbidHit)
    begin
      keyValid_q  <= 1'b1;
      keyStream_q <= streamIdentifier;
      keyPage_q   <= inputAddress[63:MERGE_LSB];
    end
    else if (txnRec | fetchRec)
      keyValid_q <= 1'b0;
  end

  // record and merge counters, last code
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      recCount_q   <= 16'h0;
      mergeCount_q <= 16'h0;
      lastCode_q   <= 8'h0;
    end
    else
    begin
      if (txnRec | fetchRec)
      begin
        recCount_q <= recCount_q + 16'h1;
        lastCode_q <= recNext[0][7:0];
      end
      if (txnTake & mergeHit)
        mergeCount_q <= mergeCount_q + 16'h1;
    end
  end

  // software control and mask
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end
    else
    begin
      if (apbWr & hitCtrl)
        ctrl_q <= pwdata[3:0];
      if (apbWr & hitMask)
        mask_q <= pwdata[EVT_NUM-1:0];
    end
  end

  // sticky status bits, one per event
  genvar g;
  generate
    for (g = 0; g < EVT_NUM; g++)
    begin : gen_stat
      tfc_sticky_bit u_bit
      (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setEvt  (evtSet[g]),
        .clrBit  (apbWr & hitStat & pwdata[g]),
        .maskBit (mask_q[g]),
        .stat    (statBits[g]),
        .pend    (pendBits[g])
      );
    end
  endgenerate
  assign irq = |pendBits;
  // read mux, zero wait states, unmapped answers with an error
  assign pready  = 1'b1;
  assign pslverr = apbAcc & ~hitAny;
  assign prdata  = ~apbAcc ? 32'h0 :
                   hitCtrl  ? {28'h0, ctrl_q} :
                   hitStat  ? {28'h0, statBits} :
                   hitMask  ? {28'h0, mask_q} :
                   hitCount ? {mergeCount_q, recCount_q} :
                   hitLast  ? {23'h0, ~idle, lastCode_q} : 32'h0;
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_forbid_code: assert property (
    txnTake & txnTranslated & ~bypassDenied & ~secureStreamFlag & ~globalEnable & ~mergeHit
    |=> recValid && recData[7:0] == CODE_FORBID && wordCnt_q == 3'h0)
    else $error("forbidden event not recorded for disabled unit");
  chk_disabled_flag: assert property (
    txnTake & txnTranslated & ~globalEnable |=> statBits[EVT_FORBID])
    else $error("disabled unit did not flag forbidden event");
  chk_bypass_denied: assert property (
    txnTake & txnTranslated & atsCheck & entryValid
    & entryStageConfiguration == CFG_FULL_BYPASS & ~mergeHit
    |=> recData[7:0] == CODE_FORBID)
    else $error("full bypass translated traffic not forbidden");
  chk_secure_forbid: assert property (
    txnTake & txnTranslated & secureStreamFlag & ~mergeHit
    |=> recValid && recData[7:0] == CODE_FORBID)
    else $error("secure translated traffic not forbidden");
  chk_merge_drop: assert property (
    txnTake & mergeHit |=> !recValid && mergeCount_q == $past(mergeCount_q) + 16'h1)
    else $error("identical forbidden event not merged");
  chk_badsub_word: assert property (
    txnTake & ~forbidHit & substreamValid & ~entryStageConfiguration[0]
    |=> recData[7:0] == CODE_BADSUB && !recData[W0_VALID_BIT]
        && recData[31:W0_SUB_LSB] == $past(substreamIdentifier))
    else $error("bad substream record wrong");
  chk_pointer_index: assert property (
    fetchTake & ~abortHit & fetchPointerRange & ~dssZero
    |=> recData[31:W0_SUB_LSB] == $past(fetchDescIndex))
    else $error("pointer range record lacks descriptor index");
  chk_default_zero: assert property (
    fetchTake & ~abortHit & fetchPointerRange & dssZero
    |=> recData[31:W0_SUB_LSB] == '0)
    else $error("default substream record not zero");
  chk_abort_reserved: assert property (
    fetchTake & abortHit & firstRev
    |=> recWords_q[7][19:16] == 4'h0 && recWords_q[2] == $past(fetchCause))
    else $error("first revision fetch address top bits not zero");
  chk_record_length: assert property (
    recTake & recLast |=> !recValid && $past(wordCnt_q) == 3'h7)
    else $error("record not eight words");
endmodule // tfc_classifier
`default_nettype wire

// [sim/tfc_requester_model.sv]
// requester model presenting transactions with their stream entry fields
`timescale 1ns/100ps
`default_nettype none
module tfc_requester_model
  import tfc_pkg::*;
#(
  parameter int SUB_W = 20
)
(
  input  wire logic        sys_clk,
  input  wire logic        txnReady,
  output logic             txnValid,
  output logic             txnTranslated,
  output logic             secureStreamFlag,
  output logic [31:0]      streamIdentifier,
  output logic             substreamValid,
  output logic [SUB_W-1:0] substreamIdentifier,
  output logic [63:0]      inputAddress,
  output logic             entryValid,
  output logic [1:0]       entryAtsPermission,
  output logic [2:0]       entryStageConfiguration,
  output logic [SUB_W-1:0] substreamLimitField
);
  // idle bus at time zero
  initial
  begin
    {txnValid, txnTranslated, secureStreamFlag, streamIdentifier, substreamValid} = '0;
    {substreamIdentifier, inputAddress, entryValid, entryAtsPermission} = '0;
    {entryStageConfiguration, substreamLimitField} = '0;
  end

  // one request held until the edge that sees ready, flags f = {tr, sec, sv, ev, ats}
  task automatic send(input logic [5:0] f, input logic [31:0] sid,
                      input logic [SUB_W-1:0] ss, input logic [SUB_W-1:0] lim,
                      input logic [63:0] ia, input logic [2:0] cfg, output logic ok);
    int n;
    @(posedge sys_clk);
    txnValid <= 1'b1;
    {txnTranslated, secureStreamFlag, substreamValid, entryValid, entryAtsPermission} <= f;
    streamIdentifier <= sid;
    substreamIdentifier <= ss;
    substreamLimitField <= lim;
    inputAddress <= ia;
    entryStageConfiguration <= cfg;
    ok = 1'b0;
    for (n = 0; n < 40; n++)
    begin
      @(negedge sys_clk);
      if (txnReady === 1'b1)
      begin
        ok = 1'b1;
        break;
      end
    end
    @(posedge sys_clk);
    // released fields stop showing the last value
    txnValid <= 1'b0;
    streamIdentifier <= ~sid;
    substreamIdentifier <= ~ss;
    inputAddress <= ~ia;
  endtask
endmodule // tfc_requester_model
`default_nettype wire

// [sim/tb_tfc_classifier.sv]
// self-checking bench for the translation fault event classifier
`timescale 1ns/100ps
`default_nettype none
module tb_tfc_classifier
  import tfc_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, recData, streamIdentifier, rd;
  logic pready, pslverr, irq, txnValid, txnReady, txnTranslated, secureStreamFlag;
  logic substreamValid, entryValid, fetchReady, recValid, recLast, er, ok;
  logic recReady = 1'b0, fetchValid = 1'b0, fetchSubValid = 1'b0;
  logic [19:0] substreamIdentifier, substreamLimitField;
  logic [19:0] fetchSubId = 20'h0, fetchDescIndex = 20'h0;
  logic [63:0] inputAddress;
  logic [1:0]  entryAtsPermission, defaultSubstreamSelect = 2'b00;
  logic [2:0]  entryStageConfiguration, hs;
  logic [5:0]  ff = 6'h0;
  logic [51:0] fetchPhysicalAddress = 52'h0;
  int          err_total = 0, check_count = 0;
  localparam logic [31:0] STR = 32'h0000_0a5c, CAUSE = 32'h0000_00c3;
  localparam logic [51:0] FA = 52'hf_edcb_a987_654f;

  always #12.5 sys_clk = ~sys_clk;
  assign hs = {recValid, fetchReady, pready};

  tfc_classifier #(.SUB_W(20)) tfc_classifier_inst (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .txnValid, .txnReady, .txnTranslated, .secureStreamFlag, .streamIdentifier, .substreamValid,
    .substreamIdentifier, .inputAddress, .entryValid, .entryAtsPermission,
    .entryStageConfiguration, .substreamLimitField, .fetchValid, .fetchReady, .fetchStream(STR),
    .fetchSubValid, .fetchSubId, .fetchDescIndex, .defaultSubstreamSelect, .fetchAbort(ff[5]),
    .fetchRangeError(ff[4]), .fetchFirstInvalid(ff[3]), .fetchPointerRange(ff[2]),
    .fetchDescInvalid(ff[1]), .fetchDescIllegal(ff[0]), .fetchPhysicalAddress,
    .fetchCause(CAUSE), .recValid, .recReady, .recData, .recLast);

  tfc_requester_model #(.SUB_W(20)) tfc_requester_model_inst (
    .sys_clk, .txnReady, .txnValid, .txnTranslated, .secureStreamFlag, .streamIdentifier,
    .substreamValid, .substreamIdentifier, .inputAddress, .entryValid, .entryAtsPermission,
    .entryStageConfiguration, .substreamLimitField);

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic stuck;
    err_total++;
    $display("CHECK FAILED %0t wait ran out", $time);
    complete_run;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for a handshake line, seen settled before the taking edge
  task automatic wait_hi(input int k);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(negedge sys_clk);
      if (hs[k] === 1'b1)
        break;
    end
    if (n == 40)
      stuck();
  endtask

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready high
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 40)
      stuck();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic tx(input logic [5:0] f, input logic [31:0] sid, input logic [19:0] ss,
                    input logic [19:0] lim, input logic [63:0] ia, input logic [2:0] cfg);
    tfc_requester_model_inst.send(f, sid, ss, lim, ia, cfg, ok);
    if (!ok)
      stuck();
  endtask

  task automatic fr(input logic [5:0] f, input logic sv, input logic [19:0] ss,
                    input logic [19:0] idx, input logic [1:0] dss);
    @(posedge sys_clk);
    fetchValid <= 1'b1;
    ff <= f;
    fetchSubValid <= sv;
    fetchSubId <= ss;
    fetchDescIndex <= idx;
    defaultSubstreamSelect <= dss;
    fetchPhysicalAddress <= FA;
    wait_hi(1);
    @(posedge sys_clk);
    fetchValid <= 1'b0;
    ff <= 6'h0;
    fetchSubId <= ~ss;
    fetchPhysicalAddress <= ~FA;
  endtask

  // collect eight record words, word 3 always zero, recLast only on the last
  task automatic rec(input logic [31:0] e0, e1, e2, e4, e5, e6, e7);
    logic [31:0] e[8];
    e = '{e0, e1, e2, 32'h0, e4, e5, e6, e7};
    recReady <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      wait_hi(2);
      chk(recData, e[i]);
      chk({31'h0, recLast}, {31'h0, i == 7});
      @(posedge sys_clk);
    end
    recReady <= 1'b0;
  endtask

  task automatic none_rec;
    repeat (4)
    begin
      @(negedge sys_clk);
      chk({31'h0, recValid}, 32'h0);
    end
  endtask

  task automatic t_regs;
    rchk(REG_CTRL, 32'h0);
    rchk(REG_STATUS, 32'h0);
    rchk(REG_MASK, 32'h0);
    rchk(REG_COUNT, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    rchk(8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask

  task automatic t_forbid;
    apb(1'b1, REG_CTRL, 32'h7);
    tx(6'b100100, 32'h11, 20'h0, 20'h0, 64'h0000_00ab_cdef_1234, 3'b001);
    rec(32'h7, 32'h11, 0, 32'hcdef_1234, 32'hab, 0, 0);
    tx(6'b100100, 32'h11, 20'h0, 20'h0, 64'h0000_00ab_cdef_1fff, 3'b001);
    none_rec();
    rchk(REG_COUNT, 32'h0001_0001);
    tx(6'b100100, 32'h11, 20'h0, 20'h0, 64'h0000_00ab_cdef_2000, 3'b001);
    rec(32'h7, 32'h11, 0, 32'hcdef_2000, 32'hab, 0, 0);
    tx(6'b100101, 32'h22, 20'h0, 20'h0, 64'h5000, CFG_FULL_BYPASS);
    rec(32'h7, 32'h22, 0, 32'h5000, 0, 0, 0);
    tx(6'b100101, 32'h23, 20'h0, 20'h0, 64'h5000, 3'b001);
    none_rec();
    apb(1'b1, REG_CTRL, 32'h5);
    tx(6'b110101, 32'h33, 20'h0, 20'h0, 64'h6000, 3'b001);
    rec(32'h7, 32'h33, 0, 32'h6000, 0, 0, 0);
    apb(1'b1, REG_CTRL, 32'h0);
    tx(6'b100101, 32'h44, 20'h0, 20'h0, 64'h7000, 3'b001);
    rec(32'h7, 32'h44, 0, 32'h7000, 0, 0, 0);
  endtask

  task automatic t_badsub;
    apb(1'b1, REG_CTRL, 32'h1);
    tx(6'b001101, 32'h55, 20'h2, 20'h8, 64'h0, 3'b010);
    rec({20'h2, 12'h008}, 32'h55, 0, 0, 0, 0, 0);
    tx(6'b001101, 32'h55, 20'h1, 20'h0, 64'h0, 3'b001);
    rec({20'h1, 12'h008}, 32'h55, 0, 0, 0, 0, 0);
    tx(6'b001101, 32'h55, 20'h5, 20'h5, 64'h0, 3'b001);
    rec({20'h5, 12'h008}, 32'h55, 0, 0, 0, 0, 0);
    tx(6'b001101, 32'h55, 20'h4, 20'h5, 64'h0, 3'b001);
    none_rec();
  endtask

  task automatic t_fetch;
    apb(1'b1, REG_CTRL, 32'h9);
    fr(6'b100000, 1'b1, 20'h123, 20'h0, 2'b00);
    rec({20'h123, 12'h809}, STR, CAUSE, 0, 0, 32'ha987_6548, 32'hedcb);
    fr(6'b010000, 1'b0, 20'h124, 20'h0, 2'b00);
    rec({20'h124, 12'h009}, STR, CAUSE, 0, 0, 32'ha987_6548, 32'hedcb);
    apb(1'b1, REG_CTRL, 32'h1);
    fr(6'b100000, 1'b1, 20'h125, 20'h0, 2'b00);
    rec({20'h125, 12'h809}, STR, CAUSE, 0, 0, 32'ha987_6548, 32'hf_edcb);
    fr(6'b010000, 1'b0, 20'h126, 20'h0, 2'b00);
    none_rec();
    fr(6'b001000, 1'b1, 20'h321, 20'h9, 2'b00);
    rec({20'h321, 12'h008}, STR, 0, 0, 0, 0, 0);
    fr(6'b000100, 1'b1, 20'h321, 20'h777, 2'b00);
    rec({20'h777, 12'h008}, STR, 0, 0, 0, 0, 0);
    fr(6'b000100, 1'b0, 20'habc, 20'h0, DSS_INDEX_ZERO);
    rec({20'h0, 12'h008}, STR, 0, 0, 0, 0, 0);
    fr(6'b000010, 1'b1, 20'h44, 20'h0, 2'b00);
    rec({20'h44, 12'h80a}, STR, 0, 0, 0, 0, 0);
    fr(6'b000001, 1'b0, 20'h45, 20'h0, 2'b00);
    rec({20'h45, 12'h00a}, STR, 0, 0, 0, 0, 0);
  endtask

  task automatic t_irq;
    rchk(REG_STATUS, 32'hf);
    rchk(REG_LAST, 32'ha);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_MASK, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_STATUS, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rchk(REG_STATUS, 32'hd);
    apb(1'b1, REG_STATUS, 32'hd);
    rchk(REG_STATUS, 32'h0);
    rchk(REG_MASK, 32'h2);
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_forbid();
    t_badsub();
    t_fetch();
    t_irq();
    complete_run();
  end
endmodule // tb_tfc_classifier
`default_nettype wire
